// ---- csrb_regs.sv ----
/*
  CPU dedicated registers, condition-code update, interrupt-level gate,
  general-purpose register bank addressing and address-region decode.
  Assumes the execution unit on the same clock drives the update ports,
  and software reaches the registers over a plain strobe port.
*/
// The address map and the address-and-strobe port were chosen for this implementation.
// Operation
// - 16-bit program counter, resets to FFFD
// - 16-bit accumulator, low byte for bytes
// - 16-bit temporary accumulator, second operand
// - Index, extra and stack pointers, 16 bits
// - Status word: bank pointer high, flags low
// - Interrupt enable; reset clears it, level 11
// - Accept interrupt only above current level
// - Half carry from bit 3 into 4
// - Negative flag follows result MSB
// - Zero flag set on zero result
// - Overflow flag on two's-complement overflow
// - Carry from bit 7; shift-out on shifts
// - 8-bit registers, eight per bank, 32 banks
// - 64K map: I/O, data, program, vectors
`timescale 1ns/100ps
`default_nettype none

module csrb_regs
    import csrb_pkg::*;
#(
    parameter logic [csrb_pkg::WORD_W-1:0] IO_TOP = csrb_pkg::IO_TOP_DEF,
    parameter logic [csrb_pkg::WORD_W-1:0] PROG_BASE = csrb_pkg::PROG_BASE_DEF,
    parameter logic [csrb_pkg::WORD_W-1:0] VEC_BASE = csrb_pkg::VEC_BASE_DEF
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Register port
    input wire logic [csrb_pkg::ADDR_W-1:0] i_addr,
    input wire logic [csrb_pkg::WORD_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [csrb_pkg::WORD_W-1:0] o_rdata,
    // Program counter control from the execution unit
    input wire logic i_pc_inc,
    input wire logic i_pc_load,
    input wire logic [csrb_pkg::WORD_W-1:0] i_pc_value,
    // Arithmetic update
    input wire logic i_alu_go,
    input wire logic i_alu_sub,
    input wire logic i_alu_cin,
    // Shift update
    input wire logic i_shift_go,
    input wire logic [csrb_pkg::BYTE_W-1:0] i_shift_res,
    input wire logic i_shift_out,
    // Interrupt request
    input wire logic i_irq_req,
    input wire logic [1:0] i_irq_level,
    output logic o_irq_take,
    // General-purpose register access
    input wire logic i_gpr_wr,
    input wire logic [csrb_pkg::IDX_W-1:0] i_gpr_idx,
    input wire logic [csrb_pkg::BYTE_W-1:0] i_gpr_wdata,
    output logic [csrb_pkg::BYTE_W-1:0] o_gpr_rdata,
    output logic [csrb_pkg::WORD_W-1:0] o_gpr_addr,
    // Address-region decode
    input wire logic [csrb_pkg::WORD_W-1:0] i_mem_addr,
    output csrb_pkg::csrb_region_e o_region,
    // Register contents
    output logic [csrb_pkg::WORD_W-1:0] o_program_counter,
    output logic [csrb_pkg::WORD_W-1:0] o_accumulator,
    output logic [csrb_pkg::WORD_W-1:0] o_temp_accumulator,
    output logic [csrb_pkg::WORD_W-1:0] o_index_reg,
    output logic [csrb_pkg::WORD_W-1:0] o_extra_pointer,
    output logic [csrb_pkg::WORD_W-1:0] o_stack_pointer,
    output logic [csrb_pkg::WORD_W-1:0] o_program_status_word
);

    import csrb_pkg::*;

    typedef struct packed {
        logic [WORD_W-1:0] program_counter;
        logic [WORD_W-1:0] accumulator;
        logic [WORD_W-1:0] temp_accumulator;
        logic [WORD_W-1:0] index_reg;
        logic [WORD_W-1:0] extra_pointer;
        logic [WORD_W-1:0] stack_pointer;
        logic [BYTE_W-1:0] bank_pointer;
        logic [BYTE_W-1:0] cond_code_reg;
        logic [WORD_W-1:0] rdata;
        logic [WORD_W-1:0] gpr_addr;
        csrb_region_e region;
    } csrb_state_s;

    csrb_state_s st;
    csrb_state_s next_st;

    logic [BANK_W-1:0] bank_sel;
    logic [GPR_AW-1:0] gpr_index;

    // The bank number is the low five bits of the bank pointer
    assign bank_sel = st.bank_pointer[BANK_W-1:0];
    assign gpr_index = {bank_sel, i_gpr_idx};

    // Arithmetic on the low bytes of the accumulator and temporary accumulator
    always_comb
    begin
        logic [BYTE_W-1:0] opa;
        logic [BYTE_W-1:0] opb;
        logic cin;
        logic [BYTE_W:0] sum;
        logic [NIB_W:0] low;
        logic [BYTE_W-1:0] res;
        opa = '0;
        opb = '0;
        cin = 1'b0;
        sum = '0;
        low = '0;
        res = '0;

        next_st = st;

        // Software writes first, so that same-cycle hardware updates win
        if (i_wr)
        begin
            case (i_addr)
                REG_PC:
                begin
                    next_st.program_counter = i_wdata;
                end
                REG_ACC:
                begin
                    next_st.accumulator = i_wdata;
                end
                REG_TACC:
                begin
                    next_st.temp_accumulator = i_wdata;
                end
                REG_INDEX:
                begin
                    next_st.index_reg = i_wdata;
                end
                REG_EXTRA:
                begin
                    next_st.extra_pointer = i_wdata;
                end
                REG_SP:
                begin
                    next_st.stack_pointer = i_wdata;
                end
                REG_PSW:
                begin
                    next_st.bank_pointer = i_wdata[WORD_W-1:PSW_BANK_LSB];
                    next_st.cond_code_reg = i_wdata[BYTE_W-1:0];
                end
                default:
                begin
                    next_st.rdata = st.rdata;
                end
            endcase
        end

        // Load beats increment when both arrive together
        if (i_pc_load)
        begin
            next_st.program_counter = i_pc_value;
        end
        else if (i_pc_inc)
        begin
            next_st.program_counter = st.program_counter + PC_STEP;
        end

        if (i_alu_go)
        begin
            // Subtraction adds the inverted operand; carry then reads as borrow
            opa = st.accumulator[BYTE_W-1:0];
            opb = st.temp_accumulator[BYTE_W-1:0] ^ {BYTE_W{i_alu_sub}};
            cin = i_alu_cin ^ i_alu_sub;
            sum = {1'b0, opa} + {1'b0, opb} + {{BYTE_W{1'b0}}, cin};
            low = {1'b0, opa[NIB_W-1:0]} + {1'b0, opb[NIB_W-1:0]}
                + {{NIB_W{1'b0}}, cin};
            res = sum[BYTE_W-1:0];
            next_st.accumulator[BYTE_W-1:0] = res;
            next_st.cond_code_reg[CC_H] = low[NIB_W] ^ i_alu_sub;
            next_st.cond_code_reg[CC_N] = res[MSB8];
            next_st.cond_code_reg[CC_Z] = (res == BYTE_CLEAR);
            next_st.cond_code_reg[CC_V] = (opa[MSB8] == opb[MSB8])
                && (res[MSB8] != opa[MSB8]);
            next_st.cond_code_reg[CC_C] = sum[BYTE_W] ^ i_alu_sub;
        end
        else if (i_shift_go)
        begin
            next_st.accumulator[BYTE_W-1:0] = i_shift_res;
            next_st.cond_code_reg[CC_N] = i_shift_res[MSB8];
            next_st.cond_code_reg[CC_Z] = (i_shift_res == BYTE_CLEAR);
            next_st.cond_code_reg[CC_C] = i_shift_out;
        end

        // Read data stand only in the cycle after the strobe
        next_st.rdata = WORD_CLEAR;
        if (i_rd)
        begin
            case (i_addr)
                REG_PC:
                begin
                    next_st.rdata = st.program_counter;
                end
                REG_ACC:
                begin
                    next_st.rdata = st.accumulator;
                end
                REG_TACC:
                begin
                    next_st.rdata = st.temp_accumulator;
                end
                REG_INDEX:
                begin
                    next_st.rdata = st.index_reg;
                end
                REG_EXTRA:
                begin
                    next_st.rdata = st.extra_pointer;
                end
                REG_SP:
                begin
                    next_st.rdata = st.stack_pointer;
                end
                REG_PSW:
                begin
                    next_st.rdata = {st.bank_pointer, st.cond_code_reg};
                end
                default: next_st.rdata = WORD_CLEAR;
            endcase
        end

        // Bank registers sit at the bottom of the data area
        next_st.gpr_addr = IO_TOP + {{(WORD_W-GPR_AW){1'b0}}, gpr_index};

        // Vector table is carved out of the top of program space
        if (i_mem_addr < IO_TOP)
        begin
            next_st.region = CSRB_RGN_IO;
        end
        else if (i_mem_addr < PROG_BASE)
        begin
            next_st.region = CSRB_RGN_DATA;
        end
        else if (i_mem_addr < VEC_BASE)
        begin
            next_st.region = CSRB_RGN_PROG;
        end
        else
        begin
            next_st.region = CSRB_RGN_VECTOR;
        end

        // Registers left undefined by the core are cleared for determinism
        if (i_rst)
        begin
            next_st.program_counter = PC_RESET;
            next_st.accumulator = WORD_CLEAR;
            next_st.temp_accumulator = WORD_CLEAR;
            next_st.index_reg = WORD_CLEAR;
            next_st.extra_pointer = WORD_CLEAR;
            next_st.stack_pointer = WORD_CLEAR;
            next_st.bank_pointer = BYTE_CLEAR;
            next_st.cond_code_reg = BYTE_CLEAR;
            next_st.cond_code_reg[CC_I] = 1'b0;
            next_st.cond_code_reg[CC_LVL1:CC_LVL0] = IL_RESET;
            next_st.rdata = WORD_CLEAR;
            next_st.gpr_addr = WORD_CLEAR;
            next_st.region = CSRB_RGN_IO;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        st <= next_st;
    end

    // Lower code means higher priority, so strictly below the level wins
    assign o_irq_take = i_irq_req && st.cond_code_reg[CC_I]
        && (i_irq_level < st.cond_code_reg[CC_LVL1:CC_LVL0]);

    csrb_bank_ram #(
        .AW(GPR_AW),
        .DW(BYTE_W)
    ) u_bank_ram (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_wr(i_gpr_wr),
        .i_waddr(gpr_index),
        .i_wdata(i_gpr_wdata),
        .i_raddr(gpr_index),
        .o_rdata(o_gpr_rdata)
    );

    assign o_rdata = st.rdata;
    assign o_gpr_addr = st.gpr_addr;
    assign o_region = st.region;
    assign o_program_counter = st.program_counter;
    assign o_accumulator = st.accumulator;
    assign o_temp_accumulator = st.temp_accumulator;
    assign o_index_reg = st.index_reg;
    assign o_extra_pointer = st.extra_pointer;
    assign o_stack_pointer = st.stack_pointer;
    assign o_program_status_word = {st.bank_pointer, st.cond_code_reg};

endmodule

`default_nettype wire

// ---- csrb_pkg.sv ----
/*
  Shared constants for the CPU dedicated registers and register banks:
  register-port offsets, reset values, condition-code bit positions,
  bank geometry and the memory-region codes.
  Assumes a 16-bit register port and an 8-bit data path in the core.
*/
`default_nettype none

package csrb_pkg;

    // Widths
    localparam int WORD_W = 16;
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 8;
    localparam int BANK_W = 5;
    localparam int IDX_W = 3;
    localparam int GPR_AW = BANK_W + IDX_W;

    // Register-port offsets
    localparam logic [ADDR_W-1:0] REG_PC = 8'h00;
    localparam logic [ADDR_W-1:0] REG_ACC = 8'h01;
    localparam logic [ADDR_W-1:0] REG_TACC = 8'h02;
    localparam logic [ADDR_W-1:0] REG_INDEX = 8'h03;
    localparam logic [ADDR_W-1:0] REG_EXTRA = 8'h04;
    localparam logic [ADDR_W-1:0] REG_SP = 8'h05;
    localparam logic [ADDR_W-1:0] REG_PSW = 8'h06;

    // Reset values and program-counter step
    localparam logic [WORD_W-1:0] PC_RESET = 16'hfffd;
    localparam logic [WORD_W-1:0] WORD_CLEAR = 16'h0000;
    localparam logic [BYTE_W-1:0] BYTE_CLEAR = 8'h00;
    localparam logic [1:0] IL_RESET = 2'h3;
    localparam logic [WORD_W-1:0] PC_STEP = 16'h0001;

    // Condition-code bit positions
    localparam int CC_C = 0;
    localparam int CC_V = 1;
    localparam int CC_Z = 2;
    localparam int CC_N = 3;
    localparam int CC_LVL0 = 4;
    localparam int CC_LVL1 = 5;
    localparam int CC_I = 6;
    localparam int CC_H = 7;

    // Byte halves of the status word and nibble split
    localparam int PSW_BANK_LSB = 8;
    localparam int NIB_W = 4;
    localparam int MSB8 = 7;

    // Address-space map
    localparam logic [WORD_W-1:0] IO_TOP_DEF = 16'h0080;
    localparam logic [WORD_W-1:0] PROG_BASE_DEF = 16'h8000;
    localparam logic [WORD_W-1:0] VEC_BASE_DEF = 16'hffc0;

    typedef enum logic [1:0] {
        CSRB_RGN_IO,
        CSRB_RGN_DATA,
        CSRB_RGN_PROG,
        CSRB_RGN_VECTOR
    } csrb_region_e;

endpackage

`default_nettype wire

// ---- csrb_bank_ram.sv ----
/*
  Data memory that holds the banked general-purpose registers.
  Assumes one write port and one read port on the same clock; the read
  data leave a register one cycle after the address is presented.
*/
`timescale 1ns/100ps
`default_nettype none

module csrb_bank_ram #(
    parameter int AW = 8,
    parameter int DW = 8
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Write side
    input wire logic i_wr,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [DW-1:0] i_wdata,
    // Read side
    input wire logic [AW-1:0] i_raddr,
    output logic [DW-1:0] o_rdata
);

    typedef struct packed {
        logic [(1<<AW)-1:0][DW-1:0] mem;
        logic [DW-1:0] rdata;
    } csrb_ram_s;

    csrb_ram_s st;
    csrb_ram_s next_st;

    // Reset clears only the read register; memory contents stay as written
    always_comb
    begin
        next_st = st;
        next_st.rdata = st.mem[i_raddr];
        if (i_wr)
        begin
            next_st.mem[i_waddr] = i_wdata;
        end
        if (i_rst)
        begin
            next_st.rdata = '0;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        st <= next_st;
    end

    assign o_rdata = st.rdata;

endmodule

`default_nettype wire

// ---- csrb_chk.sv ----
/*
  Port assertions for the CPU register block.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps
`default_nettype none
module csrb_chk #(
    parameter logic [15:0] IO_TOP = 16'h0080
) (
    // Watched ports
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_pc_inc,
    input wire logic i_pc_load,
    input wire logic i_alu_go,
    input wire logic i_shift_go,
    input wire logic i_shift_out,
    input wire logic i_irq_req,
    input wire logic [1:0] i_irq_level,
    input wire logic o_irq_take,
    input wire logic [2:0] i_gpr_idx,
    input wire logic [15:0] o_gpr_addr,
    input wire logic [15:0] o_program_counter,
    input wire logic [15:0] o_accumulator,
    input wire logic [15:0] o_program_status_word
);
    wire logic [7:0] bank_idx = {o_program_status_word[12:8], i_gpr_idx};
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);
    // Hardware flag updates win, so only a clean status write is checked
    sequence s_psw_wr;
        i_wr && i_addr == 8'h06 && !i_alu_go && !i_shift_go;
    endsequence
    a_pc_reset: assert property ($fell(i_rst) |-> o_program_counter == 16'hfffd)
        else $error("pc reset value");
    a_pc_step: assert property (i_pc_inc && !i_pc_load |=>
        o_program_counter == $past(o_program_counter) + 16'h0001) else $error("pc step");
    a_il_reset: assert property ($fell(i_rst) |-> o_program_status_word[6:4] == 3'h3)
        else $error("irq level reset");
    a_irq_gate: assert property (o_irq_take == (i_irq_req && o_program_status_word[6] &&
        i_irq_level < o_program_status_word[5:4])) else $error("irq gate");
    a_zero_flag: assert property (i_alu_go |=>
        o_program_status_word[2] == (o_accumulator[7:0] == 8'h00)) else $error("zero flag");
    a_neg_flag: assert property (i_alu_go || i_shift_go |=>
        o_program_status_word[3] == o_accumulator[7]) else $error("negative flag");
    a_shift_carry: assert property (i_shift_go && !i_alu_go |=>
        o_program_status_word[0] == $past(i_shift_out)) else $error("shift carry");
    a_bank_addr: assert property (1'b1 |=>
        o_gpr_addr == IO_TOP + $past(bank_idx)) else $error("bank address");
    a_psw_split: assert property (s_psw_wr |=>
        o_program_status_word == $past(i_wdata)) else $error("status write");
endmodule
bind csrb_regs csrb_chk #(.IO_TOP(IO_TOP)) u_chk (
    .i_ref_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_pc_inc, .i_pc_load, .i_alu_go,
    .i_shift_go, .i_shift_out, .i_irq_req, .i_irq_level, .o_irq_take, .i_gpr_idx,
    .o_gpr_addr, .o_program_counter, .o_accumulator, .o_program_status_word);
`default_nettype wire

// ---- csrb_exec.sv ----
/*
  Execution-unit model: turns a bench command into one-cycle strobes.
  Assumes a command held for one cycle; strobes follow one edge later.
*/
`timescale 1ns/100ps
`default_nettype none
module csrb_exec (
    // Clock and command
    input wire logic i_ref_clk,
    input wire logic i_go,
    input wire logic [2:0] i_op,
    input wire logic [15:0] i_arg,
    // Strobes toward the register block
    output logic o_pc_inc,
    output logic o_pc_load,
    output logic [15:0] o_pc_value,
    output logic o_alu_go,
    output logic o_alu_sub,
    output logic o_alu_cin,
    output logic o_shift_go,
    output logic [7:0] o_shift_res,
    output logic o_shift_out
);
    initial
    begin
        {o_pc_inc, o_pc_load, o_pc_value, o_alu_go, o_alu_sub} = '0;
        {o_alu_cin, o_shift_go, o_shift_res, o_shift_out} = '0;
    end
    // Operands other than o_alu_cin and o_shift_out are scrambled outside a command; those two always follow i_arg[8]
    always @(posedge i_ref_clk)
    begin
        o_pc_inc <= i_go && (i_op == 3'h1 || i_op == 3'h3);
        o_pc_load <= i_go && i_op[2:1] == 2'h1;
        o_alu_go <= i_go && i_op[2] && (i_op[0] || !i_op[1]);
        o_shift_go <= i_go && i_op[2:1] == 2'h3;
        o_alu_sub <= i_go ? i_op[0] : !o_alu_sub;
        o_pc_value <= i_go ? i_arg : ~o_pc_value;
        o_shift_res <= i_go ? i_arg[7:0] : ~o_shift_res;
        o_alu_cin <= i_arg[8];
        o_shift_out <= i_arg[8];
    end
endmodule
`default_nettype wire

// ---- cpu_status_and_register_banks_bench.sv ----
/*
  Self-checking bench for the CPU register block with a reference model.
  Assumes the execution-unit model drives the update strobes.
*/
`timescale 1ns/100ps
`default_nettype none
module cpu_status_and_register_banks_bench;
    import csrb_pkg::*;
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_wr = 1'b0, i_rd = 1'b0, i_irq_req = 1'b0, i_gpr_wr = 1'b0, p_go = 1'b0;
    logic [7:0] i_addr = 8'h00, i_gpr_wdata = 8'h00, i_shift_res, o_gpr_rdata;
    logic [15:0] i_wdata = 16'h0000, i_mem_addr = 16'h0000, p_arg = 16'h0000;
    logic [1:0] i_irq_level = 2'h0;
    logic [2:0] i_gpr_idx = 3'h0, p_op = 3'h0;
    logic i_pc_inc, i_pc_load, i_alu_go, i_alu_sub, i_alu_cin, i_shift_go, i_shift_out;
    logic o_irq_take;
    logic [15:0] i_pc_value, o_rdata, o_gpr_addr, o_program_counter, o_accumulator;
    logic [15:0] o_temp_accumulator, o_index_reg, o_extra_pointer, o_stack_pointer;
    logic [15:0] o_program_status_word;
    csrb_region_e o_region;
    logic [31:0] lf = 32'ha9ce;
    logic [15:0] ra [8] = '{16'h0000, 16'h007f, 16'h0080, 16'h7fff, 16'h8000, 16'hffbf,
        16'hffc0, 16'hffff};
    int err_total = 0, n_checks = 0, pc, acc, mp, gm [16];

    csrb_exec u_exec (.i_ref_clk, .i_go(p_go), .i_op(p_op), .i_arg(p_arg),
        .o_pc_inc(i_pc_inc), .o_pc_load(i_pc_load), .o_pc_value(i_pc_value),
        .o_alu_go(i_alu_go), .o_alu_sub(i_alu_sub), .o_alu_cin(i_alu_cin),
        .o_shift_go(i_shift_go), .o_shift_res(i_shift_res), .o_shift_out(i_shift_out));
    csrb_regs uut (.i_ref_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
        .i_pc_inc, .i_pc_load, .i_pc_value, .i_alu_go, .i_alu_sub, .i_alu_cin,
        .i_shift_go, .i_shift_res, .i_shift_out, .i_irq_req, .i_irq_level, .o_irq_take,
        .i_gpr_wr, .i_gpr_idx, .i_gpr_wdata, .o_gpr_rdata, .o_gpr_addr, .i_mem_addr,
        .o_region, .o_program_counter, .o_accumulator, .o_temp_accumulator, .o_index_reg,
        .o_extra_pointer, .o_stack_pointer, .o_program_status_word);

    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string nm);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1 chk(o_rdata, e, "rdata");
    endtask
    // Command reaches the block two edges after it is issued
    task automatic ex(input logic [2:0] op, input logic [15:0] arg);
        @(posedge i_ref_clk);
        p_go <= 1'b1;
        p_op <= op;
        p_arg <= arg;
        @(posedge i_ref_clk);
        p_go <= 1'b0;
        @(posedge i_ref_clk);
        #1;
    endtask
    task automatic alu(input int a, input int b, input int s, input int c);
        int r, h, v;
        r = s ? a - b - c : a + b + c;
        h = s ? (a & 15) < (b & 15) + c : (a & 15) + (b & 15) + c > 15;
        v = s ? (a ^ b) & (a ^ r) & 128 : ~(a ^ b) & (a ^ r) & 128;
        mp = (mp & 'hff70) | (h << 7) | ((r >> 4) & 8) | (((r & 255) == 0) << 2);
        mp = mp | ((v != 0) << 1) | ((r >> 8) & 1);
        acc = (acc & 'hff00) | (r & 255);
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        forever #2.5 i_ref_clk = ~i_ref_clk;
    end
    initial
    begin
        repeat (20000) @(posedge i_ref_clk);
        err_total++;
        give_verdict();
    end
    initial
    begin
        for (int ps = 0; ps < 2; ps++)
        begin
            i_rst <= 1'b1;
            repeat (6) @(posedge i_ref_clk);
            i_rst <= 1'b0;
            for (int r = 0; r < 7; r++)
                rd(r, r == 0 ? PC_RESET : r == 6 ? 16'h0030 : 16'h0000);
            if (ps == 0)
            begin
                for (int r = 0; r < 8; r++)
                begin
                    lf = nxt(lf);
                    wr(r, lf[15:0]);
                    rd(r, r < 7 ? lf[15:0] : 16'h0000);
                    case (r)
                        2: chk(o_temp_accumulator, lf[15:0], "tacc_out");
                        3: chk(o_index_reg, lf[15:0], "index_out");
                        4: chk(o_extra_pointer, lf[15:0], "extra_out");
                        5: chk(o_stack_pointer, lf[15:0], "stack_out");
                        default: ;
                    endcase
                end
                for (int k = 0; k < 4; k++)
                begin
                    lf = nxt(lf);
                    pc = k == 0 ? 'hfffe : k == 3 ? lf[15:0] : (pc + 1) & 'hffff;
                    ex(k == 0 ? 3'h2 : k == 3 ? 3'h3 : 3'h1, k == 0 ? 16'hfffe : lf[15:0]);
                    chk(o_program_counter, 16'(pc), "pc");
                end
                mp = 'h1f30;
                wr(6, 16'h1f30);
                for (int k = 0; k < 48; k++)
                begin
                    int a, b, s, c;
                    lf = nxt(lf);
                    a = k == 0 ? 255 : lf[7:0];
                    b = k == 0 ? 1 : k == 1 ? a : lf[15:8];
                    s = k == 1 ? 1 : lf[16];
                    c = k > 1 ? lf[17] : 0;
                    acc = lf[31:24] * 256 + a;
                    wr(1, 16'(acc));
                    wr(2, {lf[23:16], 8'(b)});
                    if (k < 40)
                    begin
                        alu(a, b, s, c);
                        ex(s ? 3'h5 : 3'h4, 16'(c << 8));
                    end
                    else
                    begin
                        acc = (acc & 'hff00) | b;
                        mp = (mp & 'hfff2) | (b & 128) >> 4 | (b == 0) << 2 | c;
                        ex(3'h6, 16'(c * 256 + b));
                    end
                    chk(o_accumulator, 16'(acc), "acc");
                    chk(o_program_status_word, 16'(mp), "ccr");
                end
                for (int k = 0; k < 8; k++)
                begin
                    wr(6, 16'(k << 4));
                    for (int l = 0; l < 4; l++)
                    begin
                        lf = nxt(lf);
                        @(posedge i_ref_clk);
                        i_irq_req <= lf[0] || l < 3;
                        i_irq_level <= 2'(l);
                        #1 chk(o_irq_take, (lf[0] || l < 3) && k[2] && l < k[1:0], "irq");
                    end
                end
                for (int k = 0; k < 32; k++)
                begin
                    if (k[2:0] == 3'h0)
                        wr(6, {3'h0, {5{k[3]}}, 8'h30});
                    lf = nxt(lf);
                    @(posedge i_ref_clk);
                    i_gpr_idx <= k[2:0];
                    i_gpr_wdata <= lf[7:0];
                    i_gpr_wr <= !k[4];
                    @(posedge i_ref_clk);
                    i_gpr_wr <= 1'b0;
                    if (!k[4])
                        gm[k[3:0]] = lf[7:0];
                    @(posedge i_ref_clk);
                    #1 chk(o_gpr_rdata, 16'(gm[k[3:0]]), "gpr");
                    chk(o_gpr_addr, 16'h0080 + {{5{k[3]}}, k[2:0]}, "gpr_addr");
                end
                for (int k = 0; k < 8; k++)
                begin
                    @(posedge i_ref_clk);
                    i_mem_addr <= ra[k];
                    @(posedge i_ref_clk);
                    #1 chk(16'(o_region), 16'(k / 2), "region");
                end
            end
        end
        give_verdict();
    end
endmodule
`default_nettype wire
